// ### verilog/adc_sweep_sequencer.sv
`timescale 1ns/1ps
`include "adc_sweep_cfg.svh"
module adc_sweep_sequencer #(
    parameter int unsigned CONV_CYC = `CONV_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    // Analog front end
    output adc_sweep_pkg::analog_sel_s analog_sel,
    output logic ref_connect,
    output logic sampling,
    input wire logic [`RES_W-1:0] sample_data,
    // External trigger pin
    input wire logic external_trigger_pin,
    // Interrupt
    output logic irq
);
    import adc_sweep_pkg::*;

    ctrl_a_s ctrl_a_reg, ctrl_a_next; // Run, trigger, mode
    ctrl_b_s ctrl_b_reg, ctrl_b_next; // Reference, resolution, width
    logic [1:0] ctrl_c_reg, ctrl_c_next; // Input group select
    logic irq_stat_reg, irq_stat_next; // Sticky sweep-done flag
    logic irq_mask_reg, irq_mask_next; // Interrupt enable
    sweep_state_e state_reg, state_next; // Sequencer state
    logic [2:0] ch_reg, ch_next; // Input being converted
    logic [`RES_W-1:0] result_reg [8]; // conversion_result_regs
    logic [`RES_W-1:0] result_next [8];
    logic [`REF_CNT_W-1:0] ref_cnt_reg, ref_cnt_next; // Reference settle count
    logic [31:0] rd_data_reg, rd_data_next; // Read answer
    logic trig_meta_reg, trig_sync_reg, trig_prev_reg; // Pin synchroniser
    logic trig_fall; // Falling edge seen on the pin
    logic wr_a, wr_b, wr_c; // Control write decodes
    logic run_wr_one, run_wr_zero; // Run bit written high or low
    logic conv_start, conv_abort; // Commands to conversion timer
    logic conv_busy, conv_done; // Timer status
    logic [`RES_W-1:0] conv_result; // Timer result
    logic sweep_end; // Single sweep finished normally
    logic ref_ready; // Reference has settled

    // Last input of the group for a width code
    // width sets last input
    function automatic logic [2:0] last_ch(input logic [1:0] width);
        return {width, 1'b1};
    endfunction

    // Write decodes
    assign wr_a = wr_en && (addr == `OFS_CTRL_A);
    assign wr_b = wr_en && (addr == `OFS_CTRL_B);
    assign wr_c = wr_en && (addr == `OFS_CTRL_C);
    assign run_wr_one = wr_a && wr_data[`CA_RUN];
    assign run_wr_zero = wr_a && !wr_data[`CA_RUN];

    // Trigger pin passes two flops before the edge detector
    always_ff @(posedge core_clk) begin
        if (rst) begin
            trig_meta_reg <= 1'b1;
            trig_sync_reg <= 1'b1;
            trig_prev_reg <= 1'b1;
        end else begin
            trig_meta_reg <= external_trigger_pin;
            trig_sync_reg <= trig_meta_reg;
            trig_prev_reg <= trig_sync_reg;
        end
    end
    assign trig_fall = trig_prev_reg && !trig_sync_reg;

    // Sweep sequencer next-state
    always_comb begin
        state_next = state_reg;
        ch_next = ch_reg;
        conv_start = 1'b0;
        conv_abort = 1'b0;
        sweep_end = 1'b0;
        unique case (state_reg)
            idle_st: begin
                if (run_wr_one) begin
                    // wait for the pin only after run is set
                    if (wr_data[`CA_TRG]) begin
                        state_next = arm_st;
                    end else begin
                        state_next = conv_st;
                        conv_start = 1'b1;
                        ch_next = 3'h0;
                    end
                end
            end
            arm_st: begin
                if (run_wr_zero) begin
                    state_next = idle_st;
                end else if (trig_fall) begin
                    state_next = conv_st;
                    conv_start = 1'b1;
                    ch_next = 3'h0;
                end
            end
            conv_st: begin
                // halt at once, dropping the conversion in flight
                if (run_wr_zero) begin
                    state_next = idle_st;
                    conv_abort = 1'b1;
                end else if (conv_done) begin
                    if (ch_reg == last_ch(ctrl_b_reg.width)) begin
                        if (ctrl_a_reg.repeat_mode) begin
                            ch_next = 3'h0;
                            conv_start = 1'b1;
                        end else begin
                            state_next = idle_st;
                            sweep_end = 1'b1;
                        end
                    end else begin
                        ch_next = ch_reg + 3'h1;
                        conv_start = 1'b1;
                    end
                end
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= idle_st;
            ch_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            ch_reg <= ch_next;
        end
    end

    // Conversion timer for the selected input
    adc_conv_timer #(
        .CONV_CYC(CONV_CYC)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .start(conv_start),
        .abort(conv_abort),
        .ten_bit(ctrl_b_reg.ten_bit),
        .sample_data(sample_data),
        .busy(conv_busy),
        .done(conv_done),
        .result(conv_result)
    );

    // Control and interrupt registers next-state
    always_comb begin
        ctrl_a_next = ctrl_a_reg;
        ctrl_b_next = ctrl_b_reg;
        ctrl_c_next = ctrl_c_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        if (wr_a) begin
            ctrl_a_next = ctrl_a_s'(wr_data[2:0]);
        end else if (sweep_end && !ctrl_a_reg.trigger_ext) begin
            ctrl_a_next.run = 1'b0;
        end
        if (wr_b) begin
            ctrl_b_next = ctrl_b_s'(wr_data[3:0]);
        end
        // group chooses one of four input groups
        if (wr_c) begin
            ctrl_c_next = wr_data[`CC_GROUP_LO +: 2];
        end
        if (wr_en && addr == `OFS_IRQ_MASK) begin
            irq_mask_next = wr_data[`IRQ_DONE];
        end
        // Write one clears; a new completion in that cycle wins
        if (wr_en && addr == `OFS_IRQ_STAT && wr_data[`IRQ_DONE]) begin
            irq_stat_next = 1'b0;
        end
        if (sweep_end) begin
            irq_stat_next = 1'b1;
        end
    end

    // Control and interrupt registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_a_reg <= ctrl_a_s'(`CTRL_A_RST);
            ctrl_b_reg <= ctrl_b_s'(`CTRL_B_RST);
            ctrl_c_reg <= `CTRL_C_RST;
            irq_stat_reg <= `IRQ_RST;
            irq_mask_reg <= `IRQ_RST;
        end else begin
            ctrl_a_reg <= ctrl_a_next;
            ctrl_b_reg <= ctrl_b_next;
            ctrl_c_reg <= ctrl_c_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    // Results, reference settle count and read answer
    always_comb begin
        result_next = result_reg;
        ref_cnt_next = ref_cnt_reg;
        rd_data_next = 32'h0;
        // result goes to its input's register
        if (conv_done && state_reg == conv_st && !run_wr_zero) begin
            result_next[ch_reg] = conv_result;
        end
        // Settle count restarts on each connect; only a status hint
        if (wr_b && wr_data[`CB_REF] && !ctrl_b_reg.ref_connect) begin
            ref_cnt_next = `REF_CNT_W'(`REF_SETTLE_CYC);
        end else if (ref_cnt_reg != '0) begin
            ref_cnt_next = ref_cnt_reg - 1'b1;
        end
        if (rd_en) begin
            if (addr[7:5] == `OFS_RESULT_BASE >> 5 && addr[1:0] == 2'h0) begin
                rd_data_next = {22'h0, result_reg[addr[4:2]]};
            end else begin
                unique case (addr)
                    `OFS_CTRL_A: rd_data_next = {29'h0, ctrl_a_reg};
                    `OFS_CTRL_B: rd_data_next = {28'h0, ctrl_b_reg};
                    `OFS_CTRL_C: rd_data_next = {30'h0, ctrl_c_reg};
                    `OFS_IRQ_STAT: rd_data_next = {31'h0, irq_stat_reg};
                    `OFS_IRQ_MASK: rd_data_next = {31'h0, irq_mask_reg};
                    `OFS_STATUS: rd_data_next = {25'h0, ch_reg, ref_ready, conv_busy,
                        state_reg == arm_st, state_reg != idle_st};
                    // Unmapped addresses read as zero
                    default: rd_data_next = 32'h0;
                endcase
            end
        end
    end

    // Result and read registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                result_reg[i] <= '0;
            end
            ref_cnt_reg <= '0;
            rd_data_reg <= 32'h0;
        end else begin
            result_reg <= result_next;
            ref_cnt_reg <= ref_cnt_next;
            rd_data_reg <= rd_data_next;
        end
    end

    // Outputs
    assign ref_ready = ctrl_b_reg.ref_connect && (ref_cnt_reg == '0);
    assign rd_data = rd_data_reg;
    assign ref_connect = ctrl_b_reg.ref_connect;
    assign sampling = conv_busy;
    assign analog_sel = '{group: ctrl_c_reg, channel: ch_reg};
    assign irq = irq_stat_reg && irq_mask_reg;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_sw_start;
        (state_reg == idle_st && run_wr_one && !wr_data[`CA_TRG]) |=> (state_reg == conv_st && conv_busy && ch_reg == 3'h0);
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("software start missed");

    property p_ext_hold;
        (state_reg == arm_st && !trig_fall) |=> (state_reg != conv_st);
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("started without trigger edge");

    property p_ext_go;
        (state_reg == arm_st && trig_fall && !run_wr_zero) |=> (state_reg == conv_st && conv_busy);
    endproperty
    a_ext_go: assert property (p_ext_go) else $error("trigger edge ignored");

    property p_halt;
        (run_wr_zero && state_reg != idle_st) |=> (state_reg == idle_st && !conv_busy && !ctrl_a_reg.run);
    endproperty
    a_halt: assert property (p_halt) else $error("run clear did not halt");

    property p_ascend;
        (state_reg == conv_st && conv_done && !run_wr_zero && ch_reg != last_ch(ctrl_b_reg.width))
            |=> (ch_reg == $past(ch_reg) + 3'h1 && conv_busy);
    endproperty
    a_ascend: assert property (p_ascend) else $error("input order broken");

    property p_width;
        (state_reg == conv_st) |-> (ch_reg <= last_ch(ctrl_b_reg.width));
    endproperty
    a_width: assert property (p_width) else $error("input outside group");

    property p_single_end;
        (sweep_end && !wr_en) |=> (state_reg == idle_st && irq_stat_reg && (ctrl_a_reg.trigger_ext || !ctrl_a_reg.run));
    endproperty
    a_single_end: assert property (p_single_end) else $error("single sweep end wrong");

    property p_repeat_quiet;
        (state_reg == conv_st && ctrl_a_reg.repeat_mode && !irq_stat_reg) |=> !irq_stat_reg;
    endproperty
    a_repeat_quiet: assert property (p_repeat_quiet) else $error("repeat sweep raised request");

    property p_store;
        (state_reg == conv_st && conv_done && !run_wr_zero) |=> (result_reg[$past(ch_reg)] == $past(conv_result));
    endproperty
    a_store: assert property (p_store) else $error("result stored in wrong register");
endmodule // adc_sweep_sequencer

// ### verilog/adc_sweep_cfg.svh
`ifndef ADC_SWEEP_CFG_SVH
`define ADC_SWEEP_CFG_SVH

// Register byte offsets
`define ADDR_W 8
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_CTRL_C 8'h08
`define OFS_IRQ_STAT 8'h0C
`define OFS_IRQ_MASK 8'h10
`define OFS_STATUS 8'h14
`define OFS_RESULT_BASE 8'h20

// Field positions
`define CA_RUN 0
`define CA_TRG 1
`define CA_REP 2
`define CB_WIDTH_LO 0
`define CB_TEN 2
`define CB_REF 3
`define CC_GROUP_LO 0
`define IRQ_DONE 0

// Reset values
`define CTRL_A_RST 3'h0
`define CTRL_B_RST 4'h0
`define CTRL_C_RST 2'h0
`define IRQ_RST 1'h0

// Timing
`define CLK_PERIOD_NS 100
`define REF_SETTLE_NS 1000
`define REF_SETTLE_CYC ((`REF_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REF_CNT_W 4
`define CONV_CYC 16
`define RES_W 10

`endif

// ### verilog/adc_sweep_pkg.sv
package adc_sweep_pkg;
    // Sequencer states
    typedef enum logic [1:0] {idle_st, arm_st, conv_st} sweep_state_e;
    // Control A: run, trigger source, sweep mode
    typedef struct packed {
        logic repeat_mode;
        logic trigger_ext;
        logic run;
    } ctrl_a_s;
    // Control B: reference switch, resolution, width
    typedef struct packed {
        logic ref_connect;
        logic ten_bit;
        logic [1:0] width;
    } ctrl_b_s;
    // Analog multiplexer selection
    typedef struct packed {
        logic [1:0] group;
        logic [2:0] channel;
    } analog_sel_s;
endpackage

// ### verilog/adc_conv_timer.sv
`timescale 1ns/1ps
`include "adc_sweep_cfg.svh"
module adc_conv_timer #(
    parameter int unsigned CONV_CYC = `CONV_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control from sequencer
    input wire logic start,
    input wire logic abort,
    input wire logic ten_bit,
    // Comparator front end, same clock
    input wire logic [`RES_W-1:0] sample_data,
    // Result
    output logic busy,
    output logic done,
    output logic [`RES_W-1:0] result
);
    import adc_sweep_pkg::*;
    localparam int unsigned CW = $clog2(CONV_CYC + 1);

    logic [CW-1:0] cnt_reg, cnt_next; // Cycles left in conversion
    logic busy_reg, busy_next; // Conversion in flight
    logic done_reg, done_next; // One-cycle completion pulse
    logic [`RES_W-1:0] result_reg, result_next; // Latched code

    // Next-state for one conversion
    always_comb begin
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        result_next = result_reg;
        // Abort beats start so a halt cannot leave a stray result
        if (abort) begin
            busy_next = 1'b0;
            cnt_next = '0;
        end else if (start) begin
            busy_next = 1'b1;
            cnt_next = CW'(CONV_CYC - 1);
        end else if (busy_reg) begin
            if (cnt_reg == '0) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                result_next = ten_bit ? sample_data : {2'h0, sample_data[`RES_W-1:2]};
            end else begin
                cnt_next = cnt_reg - 1'b1;
            end
        end
    end

    // Register stage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            result_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            result_reg <= result_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
    assign result = result_reg;

    // eight-bit result keeps top bits clear
    property p_eight_bit_range;
        @(posedge core_clk) disable iff (rst)
        (busy_reg && cnt_reg == '0 && !abort && !start && !ten_bit) |=> (done_reg && result_reg[9:8] == 2'h0);
    endproperty
    a_eight_bit_range: assert property (p_eight_bit_range) else $error("eight-bit result overflowed");
endmodule // adc_conv_timer

// ### verification/adc_front_model.sv
`timescale 1ns/1ps
`include "adc_sweep_cfg.svh"
module adc_front_model (
    // Clock
    input wire logic core_clk,
    // Multiplexer and timer view, plus salt and fire from the bench
    input adc_sweep_pkg::analog_sel_s analog_sel,
    input wire logic sampling,
    input wire logic [`RES_W-1:0] salt,
    input wire logic fire,
    // Toward the sequencer
    output logic [`RES_W-1:0] sample_data,
    output logic external_trigger_pin
);
    import adc_sweep_pkg::*;
    logic [`RES_W-1:0] noise_reg = 10'h155; // Toggles so an idle front end never looks valid
    logic [2:0] low_cnt = 3'h0; // Cycles the pin still sits low
    // Each input gives a code tied to its group and channel, so a misrouted result shows
    assign sample_data = sampling ? (salt ^ {analog_sel, analog_sel}) : noise_reg;
    assign external_trigger_pin = (low_cnt == 3'h0);
    // Pin held low long enough to pass a two-flop synchroniser
    always @(posedge core_clk) begin
        noise_reg <= ~noise_reg;
        if (fire) begin
            low_cnt <= 3'h4;
        end else if (low_cnt != 3'h0) begin
            low_cnt <= low_cnt - 3'h1;
        end
    end
endmodule // adc_front_model

// ### verification/adc_sweep_sequencer_bench.sv
`timescale 1ns/1ps
`include "adc_sweep_cfg.svh"
module adc_sweep_sequencer_bench;
    import adc_sweep_pkg::*;
    localparam int unsigned CONV = 4; // Short conversions keep the run brief
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [`ADDR_W-1:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rd_data;
    analog_sel_s analog_sel;
    logic ref_connect;
    logic sampling;
    logic irq;
    logic ext_pin;
    logic [`RES_W-1:0] sample_data;
    logic [`RES_W-1:0] salt = 10'h0; // Varies per sweep so stale results differ
    logic fire = 1'b0;
    int mismatches = 0;
    int checked = 0;
    logic [15:0] lfsr = 16'h0030;
    int chan_q[$]; // Channels in the order converted
    logic prev_s = 1'b0;
    logic [2:0] prev_c = 3'h0;
    logic [1:0] grp_exp = 2'h0;
    logic [31:0] rv;
    logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};

    adc_sweep_sequencer #(.CONV_CYC(CONV)) dut (.core_clk(core_clk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .analog_sel(analog_sel),
        .ref_connect(ref_connect), .sampling(sampling), .sample_data(sample_data),
        .external_trigger_pin(ext_pin), .irq(irq));
    adc_front_model front (.core_clk(core_clk), .analog_sel(analog_sel), .sampling(sampling),
        .salt(salt), .fire(fire), .sample_data(sample_data), .external_trigger_pin(ext_pin));

    // Clock at 10 MHz
    always #50 core_clk = ~core_clk;

    // Record each new conversion as it begins
    always @(posedge core_clk) begin
        if (sampling && (!prev_s || analog_sel.channel != prev_c)) begin
            chan_q.push_back(int'(analog_sel.channel));
            check({30'h0, analog_sel.group}, {30'h0, grp_exp});
        end
        prev_s <= sampling;
        prev_c <= analog_sel.channel;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Poll until neither armed nor active; a hang ends the run
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            rd(`OFS_STATUS, rv);
            k++;
        end while (rv[1:0] !== 2'h0 && k < 200);
        if (k >= 200) begin
            mismatches++;
            complete_run();
        end
    endtask

    task automatic sweep(input int w, input int g, input logic ten, input logic ext);
        int n;
        logic [9:0] code;
        n = 2 * (w + 1);
        lfsr = lfsr_next(lfsr);
        salt <= lfsr[9:0];
        grp_exp = 2'(g);
        wr(`OFS_IRQ_MASK, {31'h0, lfsr[10]});
        wr(`OFS_CTRL_C, 32'(g));
        wr(`OFS_CTRL_B, {28'h0, 1'b1, ten, 2'(w)});
        chan_q.delete();
        wr(`OFS_CTRL_A, {29'h0, 1'b0, ext, 1'b1});
        if (ext) begin
            tick(10);
            check({31'h0, sampling}, 32'h0);
            fire <= 1'b1;
            @(posedge core_clk);
            fire <= 1'b0;
        end
        wait_idle();
        check(32'(chan_q.size()), 32'(n));
        foreach (chan_q[i]) check(32'(chan_q[i]), 32'(i));
        rd(`OFS_CTRL_A, rv);
        check(rv, ext ? 32'h3 : 32'h0);
        rd(`OFS_IRQ_STAT, rv);
        check(rv, 32'h1);
        check({31'h0, irq}, {31'h0, lfsr[10]});
        wr(`OFS_IRQ_STAT, 32'h1);
        tick(1);
        check({31'h0, irq}, 32'h0);
        for (int i = 0; i < n; i++) begin
            code = salt ^ {grp_exp, i[2:0], grp_exp, i[2:0]};
            rd(`OFS_RESULT_BASE + 8'(4 * i), rv);
            check(rv, ten ? {22'h0, code} : {24'h0, code[9:2]});
        end
        wr(`OFS_CTRL_A, 32'h0);
    endtask

    task automatic complete_run();
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected thousand or so cycles
    initial begin
        #(100 * 20000);
        mismatches++;
        complete_run();
    end

    initial begin
        int k;
        int n0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        // Reset values, unmapped slot ignored and reads zero
        wr(8'h1C, 32'hFFFFFFFF);
        foreach (offs[i]) begin
            rd(offs[i], rv);
            check(rv, 32'h0);
        end
        check({30'h0, ref_connect, irq}, 32'h0);
        // Reference first, then wait before any start
        wr(`OFS_CTRL_B, 32'h8);
        tick(12);
        check({31'h0, ref_connect}, 32'h1);
        rd(`OFS_STATUS, rv);
        check(rv & 32'h8, 32'h8);
        // Every width across groups 0 to 2, both resolutions, both triggers
        for (int w = 0; w < 4; w++) begin
            for (int g = 0; g < 3; g++) begin
                sweep(w, g, 1'((w + g) % 2), g == 1);
            end
        end
        // Repeat sweep over four inputs wraps with no interrupt
        grp_exp = 2'h0;
        wr(`OFS_CTRL_C, 32'h0);
        wr(`OFS_CTRL_B, 32'hD);
        chan_q.delete();
        wr(`OFS_CTRL_A, 32'h5);
        k = 0;
        while (chan_q.size() < 9 && k < 200) begin
            tick(1);
            k++;
        end
        // A repeat sweep that stalls ends the run
        if (k >= 200) begin
            mismatches++;
            complete_run();
        end
        wr(`OFS_CTRL_A, 32'h0);
        tick(2);
        check({31'h0, sampling}, 32'h0);
        for (int i = 0; i < 9; i++) check(32'(chan_q[i]), 32'(i % 4));
        rd(`OFS_IRQ_STAT, rv);
        check(rv, 32'h0);
        // Halt a single sweep in mid-conversion
        wr(`OFS_CTRL_B, 32'hF);
        chan_q.delete();
        wr(`OFS_CTRL_A, 32'h1);
        tick(7);
        wr(`OFS_CTRL_A, 32'h0);
        tick(2);
        check({31'h0, sampling}, 32'h0);
        n0 = chan_q.size();
        tick(40);
        check(32'(chan_q.size()), 32'(n0));
        rd(`OFS_IRQ_STAT, rv);
        check(rv, 32'h0);
        // Disarm before any edge; a later edge with run clear starts nothing
        wr(`OFS_CTRL_A, 32'h3);
        wr(`OFS_CTRL_A, 32'h0);
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        tick(10);
        check({31'h0, sampling}, 32'h0);
        rd(`OFS_STATUS, rv);
        check(rv & 32'h3, 32'h0);
        complete_run();
    end
endmodule // adc_sweep_sequencer_bench
